/* rtl/adc_ref_pkg.sv */
package adc_ref_pkg;
  // ************************************************
  // register map
  // ************************************************
  localparam logic [7:0] REF_PROG_OFFSET = 8'hDA;
  localparam logic [7:0] REF_PROG_RESET = 8'h00;
  localparam logic [7:0] RESULT_RESET = 8'h00;
  localparam int LOW_NIB_LSB = 0;
  localparam int HIGH_NIB_LSB = 4;
  localparam int NIB_W = 4;
  localparam logic [3:0] NIB_EXT = 4'h0;
  localparam logic [3:0] LOW_NIB_LIMIT = 4'hD;
  localparam logic [3:0] HIGH_NIB_LIMIT = 4'h3;
  localparam logic [7:0] RESULT_ALL_ONES = 8'hFF;
  localparam logic [7:0] RESULT_ALL_ZEROS = 8'h00;
  // ************************************************
  // timing: clocks per machine cycle, phase lengths in machine cycles
  // ************************************************
  localparam int MC_CLKS = 12;
  localparam int LOAD_MC = 2;
  localparam int SAMPLE_MC = 3;
  localparam int CONV_MC = 8;
  localparam int IRQ_LEAD_MC = 2;
  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_LOAD = 4'b0010,
    ST_SAMPLE = 4'b0100,
    ST_CONV = 4'b1000
  } conv_state_t;
endpackage

/* rtl/mc_tick_gen.sv */
`timescale 1ns/1ps
// ************************************************
// machine cycle tick, one pulse every n clocks
// ************************************************
module mc_tick_gen #(
  parameter int N = 12
) (
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  output logic tick_o
);
  logic [7:0] cnt_q;
  logic [7:0] cnt_d;
  always_comb begin
    if (cnt_q == 8'(N - 1)) begin
      cnt_d = 8'h00;
    end else begin
      cnt_d = cnt_q + 8'h01;
    end
  end
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt_q <= 8'h00;
    end else begin
      cnt_q <= cnt_d;
    end
  end
  assign tick_o = (cnt_q == 8'(N - 1));
endmodule

/* rtl/adc_ref_start_ctrl.sv */
`timescale 1ns/1ps
// Operation
// - low nibble selects lower reference step
// - high nibble selects upper reference step
// - zero nibble uses external reference level
// - result saturates outside internal reference range
// - register write starts conversion when internal
// - write aborts running conversion, starts fresh
// - start next machine cycle, busy set
// - external low starts next machine cycle
// - conversion: load, sample, resolve phases
// - busy clears, result loads last cycle
// - continuous mode restarts immediately after end, with external start only while pin low
// - external select enables pin, blocks write starts
module adc_ref_start_ctrl
  import adc_ref_pkg::*;
#(
  parameter int MC_CLOCKS = MC_CLKS,
  parameter int LOAD_CYCLES = LOAD_MC,
  parameter int SAMPLE_CYCLES = SAMPLE_MC,
  parameter int CONV_CYCLES = CONV_MC,
  parameter int IRQ_LEAD = IRQ_LEAD_MC
) (
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  input wire logic sfr_wr_i,
  input wire logic [7:0] sfr_addr_i,
  input wire logic [7:0] sfr_wdata_i,
  output logic [7:0] reference_program_reg_o,
  input wire logic external_start_select_i,
  input wire logic continuous_mode_bit_i,
  input wire logic external_trigger_pin_i,
  input wire logic cmp_above_upper_i,
  input wire logic cmp_below_lower_i,
  input wire logic [7:0] sar_value_i,
  output logic [3:0] internal_lower_ref_o,
  output logic [3:0] internal_upper_ref_o,
  output logic lower_use_external_o,
  output logic upper_use_external_o,
  output logic sample_connect_o,
  output logic conversion_busy_flag_o,
  output logic conversion_done_irq_flag_o,
  output logic [7:0] result_register_o
);
  localparam logic [7:0] LAST_LOAD = 8'(LOAD_CYCLES - 1);
  localparam logic [7:0] LAST_SAMPLE = 8'(SAMPLE_CYCLES - 1);
  localparam logic [7:0] LAST_CONV = 8'(CONV_CYCLES - 1);
  localparam logic [7:0] IRQ_POINT = 8'(CONV_CYCLES - 1 - IRQ_LEAD);
  // a write landing on a tick waits a full machine cycle, busy shows one clock later
  localparam int SW_START_MAX = MC_CLOCKS + 1;

  logic mc_tick;
  mc_tick_gen #(.N(MC_CLOCKS)) u_tick (
    .clk_sys_i(clk_sys_i),
    .rst_n_i(rst_n_i),
    .tick_o(mc_tick)
  );

  // ************************************************
  // reference program register
  // ************************************************
  logic [7:0] ref_q, ref_d;
  logic ref_wr;
  always_comb begin
    ref_wr = sfr_wr_i && (sfr_addr_i == REF_PROG_OFFSET);
    ref_d = ref_wr ? sfr_wdata_i : ref_q;
  end
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ref_q <= REF_PROG_RESET;
    end else begin
      ref_q <= ref_d;
    end
  end
  assign reference_program_reg_o = ref_q;
  // nibble 0 selects the external level itself, not ladder step 0
  assign internal_lower_ref_o = ref_q[LOW_NIB_LSB +: NIB_W];
  assign internal_upper_ref_o = ref_q[HIGH_NIB_LSB +: NIB_W];
  assign lower_use_external_o = (ref_q[LOW_NIB_LSB +: NIB_W] == NIB_EXT);
  assign upper_use_external_o = (ref_q[HIGH_NIB_LSB +: NIB_W] == NIB_EXT);

  // ************************************************
  // start requests
  // ************************************************
  // pending flag bridges a write to the next machine cycle boundary
  logic sw_pend_q, sw_pend_d, trig_prev_q, trig_prev_d, trig_low_q, trig_low_d;
  logic start_now;
  conv_state_t st_q, st_d;
  logic [7:0] cyc_q, cyc_d;
  logic busy_q, busy_d, irq_q, irq_d;
  logic [7:0] res_q, res_d;
  logic last_cyc, ext_go, ext_hi_q, ext_hi_d, ext_fall;

  always_comb begin
    sw_pend_d = sw_pend_q;
    trig_prev_d = trig_prev_q;
    trig_low_d = trig_low_q;
    if (ref_wr && !external_start_select_i) begin
      sw_pend_d = 1'b1;
    end else if (mc_tick) begin
      sw_pend_d = 1'b0;
    end
    if (mc_tick) begin
      trig_prev_d = external_trigger_pin_i;
      trig_low_d = !external_trigger_pin_i;
    end
  end
  // single external start: high sample then low sample
  always_comb begin
    ext_hi_d = ext_hi_q;
    if (mc_tick) begin
      ext_hi_d = trig_prev_q;
    end
    ext_fall = ext_hi_q && trig_low_q && external_start_select_i && !continuous_mode_bit_i;
  end

  always_comb begin
    last_cyc = (st_q == ST_CONV) && (cyc_q == LAST_CONV);
    ext_go = 1'b0;
    if (external_start_select_i && trig_low_q) begin
      if (continuous_mode_bit_i) begin
        // only from idle: a running one chains on itself, keeping its result
        ext_go = (st_q == ST_IDLE);
      end
    end
    start_now = mc_tick && (sw_pend_q || ext_go || ext_fall);
  end

  // ************************************************
  // conversion sequencer
  // ************************************************
  always_comb begin
    st_d = st_q;
    cyc_d = cyc_q;
    busy_d = busy_q;
    irq_d = irq_q;
    res_d = res_q;
    if (start_now) begin
      st_d = ST_LOAD;
      cyc_d = 8'h00;
      busy_d = 1'b1;
    end else if (mc_tick) begin
      cyc_d = cyc_q + 8'h01;
      case (st_q)
        ST_LOAD: begin
          if (cyc_q == LAST_LOAD) begin
            st_d = ST_SAMPLE;
            cyc_d = 8'h00;
          end
        end
        ST_SAMPLE: begin
          if (cyc_q == LAST_SAMPLE) begin
            st_d = ST_CONV;
            cyc_d = 8'h00;
          end
        end
        ST_CONV: begin
          if (cyc_q == IRQ_POINT) begin
            irq_d = 1'b1;
          end
          if (cyc_q == LAST_CONV - 8'h01) begin
            busy_d = 1'b0;
          end
          if (last_cyc) begin
            if (cmp_above_upper_i) begin
              res_d = RESULT_ALL_ONES;
            end else if (cmp_below_lower_i) begin
              res_d = RESULT_ALL_ZEROS;
            end else begin
              res_d = sar_value_i;
            end
            // external continuous chains on while the pin stays low
            if (continuous_mode_bit_i && (!external_start_select_i || trig_low_q)) begin
              st_d = ST_LOAD;
              cyc_d = 8'h00;
              busy_d = 1'b1;
            end else begin
              st_d = ST_IDLE;
            end
          end
        end
        default: begin
          cyc_d = 8'h00;
        end
      endcase
    end
    if (irq_q && !mc_tick) begin
      irq_d = 1'b0;
    end
  end

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sw_pend_q <= 1'b0;
      trig_prev_q <= 1'b1;
      trig_low_q <= 1'b0;
      ext_hi_q <= 1'b0;
      st_q <= ST_IDLE;
      cyc_q <= 8'h00;
      busy_q <= 1'b0;
      irq_q <= 1'b0;
      res_q <= RESULT_RESET;
    end else begin
      sw_pend_q <= sw_pend_d;
      trig_prev_q <= trig_prev_d;
      trig_low_q <= trig_low_d;
      ext_hi_q <= ext_hi_d;
      st_q <= st_d;
      cyc_q <= cyc_d;
      busy_q <= busy_d;
      irq_q <= irq_d;
      res_q <= res_d;
    end
  end

  assign sample_connect_o = (st_q == ST_LOAD) || (st_q == ST_SAMPLE);
  assign conversion_busy_flag_o = busy_q;
  assign conversion_done_irq_flag_o = irq_q;
  assign result_register_o = res_q;

  // ************************************************
  // checks
  // ************************************************
  property p_sw_start;
    @(posedge clk_sys_i) disable iff (!rst_n_i)
    (ref_wr && !external_start_select_i) |-> ##[1:SW_START_MAX] busy_q;
  endproperty
  a_sw_start: assert property (p_sw_start) else $error("write did not start");
  property p_ext_block;
    @(posedge clk_sys_i) disable iff (!rst_n_i)
    (ref_wr && external_start_select_i && !sw_pend_q) |=> !sw_pend_q;
  endproperty
  a_ext_block: assert property (p_ext_block) else $error("write started in ext mode");
  property p_restart;
    @(posedge clk_sys_i) disable iff (!rst_n_i)
    (mc_tick && sw_pend_q) |=> (st_q == ST_LOAD) && (cyc_q == 8'h00);
  endproperty
  a_restart: assert property (p_restart) else $error("abort restart failed");
  property p_busy_set;
    @(posedge clk_sys_i) disable iff (!rst_n_i)
    (st_q == ST_LOAD) |-> busy_q;
  endproperty
  a_busy_set: assert property (p_busy_set) else $error("busy not set");
  property p_phase;
    @(posedge clk_sys_i) disable iff (!rst_n_i)
    ($rose(st_q == ST_CONV)) |-> $past(st_q == ST_SAMPLE);
  endproperty
  a_phase: assert property (p_phase) else $error("phase order");
  property p_result;
    @(posedge clk_sys_i) disable iff (!rst_n_i)
    (mc_tick && last_cyc && !start_now && cmp_above_upper_i) |=> res_q == 8'hFF;
  endproperty
  a_result: assert property (p_result) else $error("no saturation");
  property p_busy_clr;
    @(posedge clk_sys_i) disable iff (!rst_n_i)
    (last_cyc && !start_now) |-> !busy_q;
  endproperty
  a_busy_clr: assert property (p_busy_clr) else $error("busy at last cycle");
  property p_ext_ref;
    @(posedge clk_sys_i) disable iff (!rst_n_i)
    lower_use_external_o == (ref_q[3:0] == 4'h0);
  endproperty
  a_ext_ref: assert property (p_ext_ref) else $error("external ref select");
  c_sw: cover property (@(posedge clk_sys_i) ref_wr && busy_q);
  c_cont: cover property (@(posedge clk_sys_i) last_cyc && mc_tick && continuous_mode_bit_i);
  c_ext: cover property (@(posedge clk_sys_i) mc_tick && ext_fall);
endmodule

/* tb/analog_side_model.sv */
`timescale 1ns/1ps
// *****
// ladder and comparator stand-in
// *****
module analog_side_model (
  input wire logic [7:0] vin_i,
  input wire logic [3:0] lower_step_i,
  input wire logic [3:0] upper_step_i,
  input wire logic lower_ext_i,
  input wire logic upper_ext_i,
  output logic cmp_above_upper_o,
  output logic cmp_below_lower_o,
  output logic [7:0] sar_value_o
);
  int lo_lvl;
  int hi_lvl;
  // levels in 1/256 of span, step k at 16*k
  always_comb begin
    lo_lvl = lower_ext_i ? 0 : 16 * int'(lower_step_i);
    hi_lvl = upper_ext_i ? 256 : 16 * int'(upper_step_i);
    cmp_above_upper_o = int'(vin_i) > hi_lvl;
    cmp_below_lower_o = int'(vin_i) < lo_lvl;
    // scrambled code, so saturation cannot pass by luck
    sar_value_o = vin_i ^ 8'h5A;
  end
endmodule

/* tb/tb.sv */
`timescale 1ns/1ps
module tb;
  import adc_ref_pkg::*;
  localparam int MC = 4;
  localparam int TC = (LOAD_MC + SAMPLE_MC + CONV_MC) * MC;
  logic clk_sys_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic wr_q = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [7:0] wdata = 8'h00;
  logic ext = 1'b0;
  logic cont = 1'b0;
  logic trig = 1'b1;
  logic [7:0] vin = 8'h00;
  logic above, below, lo_ext, hi_ext, busy, irq, seen, samp;
  logic [7:0] sar, prog, result;
  logic [3:0] lo_ref, hi_ref;
  logic [7:0] expq[$];
  int failures = 0;
  int comparisons = 0;
  int n;
  int lo;
  logic [7:0] p;
  always #4 clk_sys_i = ~clk_sys_i;
  adc_ref_start_ctrl #(.MC_CLOCKS(MC)) adc_ref_start_ctrl_inst (.clk_sys_i(clk_sys_i),
    .rst_n_i(rst_n_i), .sfr_wr_i(wr_q), .sfr_addr_i(addr), .sfr_wdata_i(wdata),
    .reference_program_reg_o(prog), .external_start_select_i(ext),
    .continuous_mode_bit_i(cont), .external_trigger_pin_i(trig),
    .cmp_above_upper_i(above), .cmp_below_lower_i(below), .sar_value_i(sar),
    .internal_lower_ref_o(lo_ref), .internal_upper_ref_o(hi_ref),
    .lower_use_external_o(lo_ext), .upper_use_external_o(hi_ext), .sample_connect_o(samp),
    .conversion_busy_flag_o(busy), .conversion_done_irq_flag_o(irq),
    .result_register_o(result));
  analog_side_model analog_side_model_inst (.vin_i(vin), .lower_step_i(lo_ref),
    .upper_step_i(hi_ref), .lower_ext_i(lo_ext), .upper_ext_i(hi_ext),
    .cmp_above_upper_o(above), .cmp_below_lower_o(below), .sar_value_o(sar));
  // *****
  // checking and bus tasks
  // *****
  task automatic summarize();
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task automatic chk(input string what, input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp) begin
      failures++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wait_for(input bit on_irq, input logic lvl, input int bound);
    n = 0;
    while ((on_irq ? irq : busy) !== lvl) begin
      @(posedge clk_sys_i);
      #1;
      n++;
      if (n > bound) begin
        failures++;
        $display("ERROR wait expected %b seen timeout", lvl);
        summarize();
      end
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys_i);
    wr_q <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk_sys_i);
    wr_q <= 1'b0;
    #1;
  endtask
  function automatic logic [7:0] model(input logic [7:0] pr, input logic [7:0] v);
    int l, h;
    l = (pr[3:0] == 4'h0) ? 0 : 16 * int'(pr[3:0]);
    h = (pr[7:4] == 4'h0) ? 256 : 16 * int'(pr[7:4]);
    if (int'(v) > h) return 8'hFF;
    if (int'(v) < l) return 8'h00;
    return v ^ 8'h5A;
  endfunction
  task automatic finish_conv();
    wait_for(1'b1, 1'b1, TC);
    @(posedge clk_sys_i);
    #1;
    chk("irq pulse", {6'h0, irq, busy}, 8'h01);
    wait_for(1'b0, 1'b0, TC);
    chk("connect end", {7'h0, samp}, 8'h00);
    repeat (3 * MC) @(posedge clk_sys_i);
    #1;
    chk("result", result, expq.pop_front());
  endtask
  task automatic start(input logic [7:0] pr);
    wr(REF_PROG_OFFSET, pr);
    chk("prog", prog, pr);
    chk("refs", {hi_ref, lo_ref}, pr);
    chk("ext flags", {6'h0, hi_ext, lo_ext}, {6'h0, pr[7:4] == 4'h0, pr[3:0] == 4'h0});
    expq.push_back(model(pr, vin));
  endtask
  task automatic quiet(input int clks);
    seen = 1'b0;
    repeat (clks) begin
      @(posedge clk_sys_i);
      #1;
      seen = seen | busy;
    end
  endtask
  // *****
  // main sequence
  // *****
  initial begin
    void'($urandom(32'h92a7a369));
    repeat (6) @(posedge clk_sys_i);
    rst_n_i <= 1'b1;
    #1;
    chk("prog rst", prog, REF_PROG_RESET);
    chk("busy rst", {7'h0, busy}, 8'h00);
    $display("test reset done");
    for (int i = 0; i < 8; i++) begin
      lo = $urandom_range(11, 0);
      p = (i == 0) ? 8'h00 : (i == 1) ? 8'hC8 : {4'($urandom_range(15, lo + 4)), 4'(lo)};
      @(posedge clk_sys_i);
      vin <= 8'($urandom_range(255, 0));
      start(p);
      wait_for(1'b0, 1'b1, MC + 2);
      finish_conv();
    end
    $display("test software start done");
    @(posedge clk_sys_i);
    vin <= 8'h80;
    start(8'hF0);
    wait_for(1'b0, 1'b1, MC + 2);
    repeat (5 * MC) @(posedge clk_sys_i);
    void'(expq.pop_front());
    start(8'h40);
    wait_for(1'b1, 1'b1, TC);
    chk("restart", 8'(n > 8 * MC), 8'h01);
    finish_conv();
    $display("test restart done");
    wr(8'hD9, 8'h55);
    quiet(3 * MC);
    chk("unmapped", {prog[6:0], seen}, 8'h80);
    @(posedge clk_sys_i);
    ext <= 1'b1;
    start(8'h80);
    quiet(3 * MC);
    chk("ext blocks wr", {7'h0, seen}, 8'h00);
    @(posedge clk_sys_i);
    trig <= 1'b0;
    wait_for(1'b0, 1'b1, 3 * MC + 2);
    chk("connect", {7'h0, samp}, 8'h01);
    finish_conv();
    @(posedge clk_sys_i);
    trig <= 1'b1;
    ext <= 1'b0;
    $display("test external start done");
    @(posedge clk_sys_i);
    cont <= 1'b1;
    start(8'h84);
    expq.push_back(expq[0]);
    finish_conv();
    wait_for(1'b0, 1'b1, MC + 2);
    @(posedge clk_sys_i);
    cont <= 1'b0;
    finish_conv();
    $display("test continuous done");
    summarize();
  end
endmodule
